// >>> logic/wdt_power_ctrl.sv
`timescale 1ns/1ps
// How it works
// RULE_01: Halt with both keep-on bits set enters the idle mode with both clocks running.
// RULE_02: In that idle mode fast and slow clocks stay on while the program halts.
// RULE_03: Halt with fast keep-on only keeps fast clock, stops slow clock, halts.
// RULE_04: Entering power-down leaves memory, registers and port states untouched.
// RULE_05: Halt sets the power-down flag and clears the watchdog expiry flag.
// RULE_06: Halt clears the watchdog counter; it runs on only if enabled.
// RULE_07: Wake on enabled port A falling edge, an interrupt, or watchdog overflow.
// RULE_08: Power-down flag clears at power-up and on the clear-watchdog instruction.
// RULE_09: Overflow in power-down sets expiry flag, resets only PC and stack pointer.
// RULE_10: Port A wake resumes at the instruction after the halt.
// RULE_11: Disabled interrupt or full stack resumes after halt; request stays pending.
// RULE_12: Enabled interrupt with a free stack level gets the normal interrupt response.
// RULE_13: An interrupt already requesting before halt cannot wake the device.
// RULE_14: Watchdog source bit 4: zero picks internal RC, one picks crystal.
// RULE_15: Period codes 000 to 111 give 2^8,10,12,14,15,16,17,18 watchdog clocks.
// RULE_16: Key 01010 enables the watchdog, key 10101 disables it.
// RULE_17: Any other key resets the device after a fixed delay, setting key-reset flag.
// RULE_18: Key-reset flag is set only by hardware, cleared only by writing zero.
// RULE_19: The key powers up holding the enable code, so the watchdog runs.
// RULE_20: Watchdog overflow in normal run resets the device; software must clear it.
// RULE_21: Counter clears on key software reset, clear-watchdog, or halt.
// RULE_22: The key is checked every cycle, so corruption alone triggers the reset.
module wdt_power_ctrl #(
  parameter int PORTA_WIDTH = 8,
  parameter int IRQ_COUNT = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [wdt_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire wdt_pkg::cpu_event_t cpu_event_in,
  input wire logic [PORTA_WIDTH-1:0] porta_in,
  input wire logic ext_crystal_32k_in,
  input wire logic [IRQ_COUNT-1:0] irq_req_in,
  input wire logic [IRQ_COUNT-1:0] irq_enable_in,
  input wire logic stack_full_in,
  input wire logic low_voltage_reset_in,
  input wire logic lv_control_reset_in,
  output wdt_pkg::clk_gate_t clk_gate_out,
  output logic device_reset_out,
  output logic pc_sp_reset_out,
  output logic resume_out,
  output logic irq_service_out
);
  import wdt_pkg::*;

  if (PORTA_WIDTH < 1 || PORTA_WIDTH > 8) begin : g_porta_check
    $error("PORTA_WIDTH must be 1 to 8");
  end
  if (IRQ_COUNT < 1 || IRQ_COUNT > 32) begin : g_irq_check
    $error("IRQ_COUNT must be 1 to 32");
  end

  // Registers
  logic [7:0] wdt_ctrl_q;
  logic [7:0] wdt_ctrl_d;
  logic [7:0] sys_clk_ctrl_q;
  logic [7:0] sys_clk_ctrl_d;
  logic [2:0] reset_cause_q;
  logic [2:0] reset_cause_d;
  logic [7:0] porta_wake_q;
  logic [7:0] porta_wake_d;
  logic power_down_flag_q;
  logic power_down_flag_d;
  logic wdt_expiry_flag_q;
  logic wdt_expiry_flag_d;
  power_mode_t mode_q;
  power_mode_t mode_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // Pin synchronisers: three stages, a change counts when stages two and three agree
  logic [PORTA_WIDTH-1:0] porta_s1_q;
  logic [PORTA_WIDTH-1:0] porta_s2_q;
  logic [PORTA_WIDTH-1:0] porta_s3_q;
  logic [PORTA_WIDTH-1:0] porta_stable_q;
  logic [PORTA_WIDTH-1:0] porta_stable_d;
  logic xtal_s1_q;
  logic xtal_s2_q;
  logic xtal_s3_q;
  logic xtal_stable_q;
  logic xtal_stable_d;

  // Watchdog tick sources and key check
  logic [8:0] rc_div_q;
  logic [8:0] rc_div_d;
  logic [11:0] key_delay_q;
  logic [11:0] key_delay_d;
  logic key_pending_q;
  logic key_pending_d;
  logic [IRQ_COUNT-1:0] irq_armed_q;
  logic [IRQ_COUNT-1:0] irq_armed_d;
  logic device_reset_q;
  logic pc_sp_reset_q;
  logic resume_q;
  logic irq_service_q;
  logic wdt_overflow;
  logic [WDT_CNT_W-1:0] wdt_count;

  // Bus decode
  wire logic bus_setup = psel_in && !penable_in;
  wire logic bus_write = psel_in && penable_in && pwrite_in;
  wire logic hit_wdt_ctrl = (paddr_in == WDT_CTRL_OFS);
  wire logic hit_sys_clk = (paddr_in == SYS_CLK_CTRL_OFS);
  wire logic hit_reset_cause = (paddr_in == RESET_CAUSE_OFS);
  wire logic hit_status = (paddr_in == PWR_STATUS_OFS);
  wire logic hit_porta_wake = (paddr_in == PORTA_WAKE_OFS);
  wire logic addr_mapped =
    hit_wdt_ctrl || hit_sys_clk || hit_reset_cause || hit_status || hit_porta_wake;
  wire logic [7:0] wdata = pwdata_in[7:0];

  // Control decode
  wire logic [4:0] unlock_key = wdt_ctrl_q[KEY_MSB:KEY_LSB];
  wire logic [2:0] wdt_period_sel = wdt_ctrl_q[PERIOD_MSB:0];
  wire logic wdt_enabled = (unlock_key == KEY_ENABLE); // RULE_16
  wire logic key_invalid = !wdt_enabled && (unlock_key != KEY_DISABLE); // RULE_17 RULE_22
  wire logic wdt_clock_source_sel = sys_clk_ctrl_q[CLK_SRC_BIT];
  wire logic fast_osc_keep_on = sys_clk_ctrl_q[FAST_KEEP_BIT];
  wire logic slow_osc_keep_on = sys_clk_ctrl_q[SLOW_KEEP_BIT];
  wire logic in_run = (mode_q == MODE_RUN);
  wire logic halt_req = cpu_event_in.halt && in_run;
  wire logic clr_wdt_req = cpu_event_in.clr_wdt && in_run;

  // Watchdog tick: internal RC modelled by a divider, crystal taken from its pin
  wire logic rc_tick = (rc_div_q == 9'(INT_RC_DIV_CYCLES - 1));
  wire logic xtal_tick = xtal_stable_d && !xtal_stable_q;
  wire logic wdt_tick_clock = wdt_clock_source_sel ? xtal_tick : rc_tick; // RULE_14
  wire logic key_fire = key_pending_q && (key_delay_q == 12'(SOFTWARE_RESET_DELAY_CYCLES - 1));
  wire logic key_start = key_invalid && !key_pending_q;
  wire logic wdt_clear = clr_wdt_req || halt_req || key_start; // RULE_21 RULE_06

  // Wake sources, only seen while powered down
  wire logic [PORTA_WIDTH-1:0] porta_fall = porta_stable_q & ~porta_stable_d;
  wire logic porta_wake =
    !in_run && |(porta_fall & porta_wake_q[PORTA_WIDTH-1:0]); // RULE_07
  wire logic [IRQ_COUNT-1:0] irq_wake_lines = irq_req_in & irq_armed_q; // RULE_13
  wire logic irq_wake = !in_run && |irq_wake_lines; // RULE_07
  wire logic irq_serviceable = |(irq_wake_lines & irq_enable_in) && !stack_full_in;
  wire logic sleep_overflow = !in_run && wdt_overflow;
  wire logic run_overflow = in_run && wdt_overflow;

  wdt_counter u_wdt_counter (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(wdt_tick_clock),
    .clear_in(wdt_clear),
    .enable_in(wdt_enabled), // RULE_06
    .period_sel_in(wdt_period_sel), // RULE_15
    .overflow_out(wdt_overflow),
    .count_out(wdt_count)
  );

  // Mode selection from the keep-on bits at halt
  always_comb begin
    mode_d = mode_q;
    if (halt_req) begin
      case ({fast_osc_keep_on, slow_osc_keep_on})
        2'b11: mode_d = MODE_IDLE_BOTH; // RULE_01
        2'b10: mode_d = MODE_IDLE_FAST; // RULE_03
        2'b01: mode_d = MODE_IDLE0;
        default: mode_d = MODE_SLEEP;
      endcase
    end else if (sleep_overflow || porta_wake || irq_wake) begin
      mode_d = MODE_RUN; // RULE_07
    end
  end

  // Clock gating follows the mode
  always_comb begin
    clk_gate_out.cpu_halted = !in_run; // RULE_02
    case (mode_q)
      MODE_RUN: begin
        clk_gate_out.fast_clk_en = 1'b1;
        clk_gate_out.slow_clk_en = 1'b1;
      end
      MODE_IDLE_BOTH: begin
        clk_gate_out.fast_clk_en = 1'b1; // RULE_02
        clk_gate_out.slow_clk_en = 1'b1;
      end
      MODE_IDLE_FAST: begin
        clk_gate_out.fast_clk_en = 1'b1; // RULE_03
        clk_gate_out.slow_clk_en = 1'b0;
      end
      MODE_IDLE0: begin
        clk_gate_out.fast_clk_en = 1'b0;
        clk_gate_out.slow_clk_en = 1'b1;
      end
      default: begin
        clk_gate_out.fast_clk_en = 1'b0;
        clk_gate_out.slow_clk_en = 1'b0;
      end
    endcase
  end

  // Status flags: a hardware set wins over a clear in the same cycle
  always_comb begin
    power_down_flag_d = power_down_flag_q;
    if (clr_wdt_req) begin
      power_down_flag_d = 1'b0; // RULE_08
    end
    if (halt_req) begin
      power_down_flag_d = 1'b1; // RULE_05
    end
    wdt_expiry_flag_d = wdt_expiry_flag_q;
    if (halt_req) begin
      wdt_expiry_flag_d = 1'b0; // RULE_05
    end
    if (wdt_overflow) begin
      wdt_expiry_flag_d = 1'b1; // RULE_09 RULE_20
    end
  end

  // Interrupts already requesting at halt are not armed for wake-up
  always_comb begin
    irq_armed_d = irq_armed_q;
    if (halt_req) begin
      irq_armed_d = ~irq_req_in; // RULE_13
    end
  end

  // Key corruption watch: reset fires a fixed delay after an invalid key appears
  always_comb begin
    key_pending_d = key_pending_q;
    key_delay_d = key_delay_q;
    if (key_start) begin
      key_pending_d = 1'b1; // RULE_22
      key_delay_d = '0;
    end else if (key_fire) begin
      key_pending_d = 1'b0;
      key_delay_d = '0;
    end else if (key_pending_q) begin
      key_delay_d = key_delay_q + 12'h001;
    end
  end

  // Register writes; nothing here reacts to power-down entry
  always_comb begin
    wdt_ctrl_d = wdt_ctrl_q; // RULE_04
    sys_clk_ctrl_d = sys_clk_ctrl_q;
    porta_wake_d = porta_wake_q;
    reset_cause_d = reset_cause_q;
    if (bus_write && hit_wdt_ctrl) begin
      wdt_ctrl_d = wdata;
    end
    if (bus_write && hit_sys_clk) begin
      sys_clk_ctrl_d = wdata & SYS_CLK_CTRL_MASK;
    end
    if (bus_write && hit_porta_wake) begin
      porta_wake_d = wdata;
    end
    if (bus_write && hit_reset_cause) begin
      reset_cause_d = reset_cause_q & wdata[2:0]; // RULE_18
    end
    if (key_fire) begin
      wdt_ctrl_d = WDT_CTRL_RESET; // RULE_17 RULE_19
      reset_cause_d[KEY_RESET_BIT] = 1'b1; // RULE_17 RULE_18
    end
    if (lv_control_reset_in) begin
      reset_cause_d[LV_CTRL_RESET_BIT] = 1'b1;
    end
    if (low_voltage_reset_in) begin
      reset_cause_d[LV_RESET_BIT] = 1'b1;
    end
  end

  // Read data is captured in the setup phase and held for the access phase
  always_comb begin
    prdata_d = prdata_q;
    if (bus_setup && !pwrite_in) begin
      prdata_d = '0;
      if (hit_wdt_ctrl) begin
        prdata_d[7:0] = wdt_ctrl_q;
      end
      if (hit_sys_clk) begin
        prdata_d[7:0] = sys_clk_ctrl_q;
      end
      if (hit_reset_cause) begin
        prdata_d[2:0] = reset_cause_q;
      end
      if (hit_porta_wake) begin
        prdata_d[7:0] = porta_wake_q;
      end
      if (hit_status) begin
        prdata_d[PDF_BIT] = power_down_flag_q;
        prdata_d[EXPIRY_BIT] = wdt_expiry_flag_q;
        prdata_d[MODE_LSB+2:MODE_LSB] = mode_q;
        prdata_d[WDT_ON_BIT] = wdt_enabled;
      end
    end
  end

  // Pin filtering
  always_comb begin
    porta_stable_d = porta_stable_q;
    for (int i = 0; i < PORTA_WIDTH; i++) begin
      if (porta_s2_q[i] == porta_s3_q[i]) begin
        porta_stable_d[i] = porta_s3_q[i];
      end
    end
    xtal_stable_d = (xtal_s2_q == xtal_s3_q) ? xtal_s3_q : xtal_stable_q;
    rc_div_d = rc_tick ? 9'h000 : rc_div_q + 9'h001;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      porta_s1_q <= '1;
      porta_s2_q <= '1;
      porta_s3_q <= '1;
      porta_stable_q <= '1;
      xtal_s1_q <= 1'b0;
      xtal_s2_q <= 1'b0;
      xtal_s3_q <= 1'b0;
      xtal_stable_q <= 1'b0;
      rc_div_q <= '0;
    end else begin
      porta_s1_q <= porta_in;
      porta_s2_q <= porta_s1_q;
      porta_s3_q <= porta_s2_q;
      porta_stable_q <= porta_stable_d;
      xtal_s1_q <= ext_crystal_32k_in;
      xtal_s2_q <= xtal_s1_q;
      xtal_s3_q <= xtal_s2_q;
      xtal_stable_q <= xtal_stable_d;
      rc_div_q <= rc_div_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wdt_ctrl_q <= WDT_CTRL_RESET; // RULE_19
      sys_clk_ctrl_q <= SYS_CLK_CTRL_RESET;
      porta_wake_q <= PORTA_WAKE_RESET;
      reset_cause_q <= '0;
      power_down_flag_q <= 1'b0; // RULE_08
      wdt_expiry_flag_q <= 1'b0;
      mode_q <= MODE_RUN;
      prdata_q <= '0;
      key_pending_q <= 1'b0;
      key_delay_q <= '0;
      irq_armed_q <= '0;
    end else begin
      wdt_ctrl_q <= wdt_ctrl_d;
      sys_clk_ctrl_q <= sys_clk_ctrl_d;
      porta_wake_q <= porta_wake_d;
      reset_cause_q <= reset_cause_d;
      power_down_flag_q <= power_down_flag_d;
      wdt_expiry_flag_q <= wdt_expiry_flag_d;
      mode_q <= mode_d;
      prdata_q <= prdata_d;
      key_pending_q <= key_pending_d;
      key_delay_q <= key_delay_d;
      irq_armed_q <= irq_armed_d;
    end
  end

  // Wake and reset pulses, one cycle each; overflow beats pins, pins beat interrupts
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      device_reset_q <= 1'b0;
      pc_sp_reset_q <= 1'b0;
      resume_q <= 1'b0;
      irq_service_q <= 1'b0;
    end else begin
      device_reset_q <= run_overflow || key_fire; // RULE_20 RULE_17
      pc_sp_reset_q <= sleep_overflow; // RULE_09
      resume_q <= !sleep_overflow && (porta_wake || (irq_wake && !irq_serviceable)); // RULE_10 RULE_11
      irq_service_q <= !sleep_overflow && !porta_wake && irq_wake && irq_serviceable; // RULE_12
    end
  end

  assign device_reset_out = device_reset_q;
  assign pc_sp_reset_out = pc_sp_reset_q;
  assign resume_out = resume_q;
  assign irq_service_out = irq_service_q;
  assign prdata_out = prdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_mapped;

endmodule // wdt_power_ctrl

// >>> common/wdt_pkg.sv
package wdt_pkg;

  // Clock and time base
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int INT_RC_FREQ_HZ = 32_000;
  localparam int INT_RC_DIV_CYCLES = CLK_FREQ_HZ / INT_RC_FREQ_HZ;
  localparam int SOFTWARE_RESET_DELAY_NS = 100_000;
  localparam int SOFTWARE_RESET_DELAY_CYCLES =
    (SOFTWARE_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] WDT_CTRL_OFS = 8'h00;
  localparam logic [7:0] SYS_CLK_CTRL_OFS = 8'h04;
  localparam logic [7:0] RESET_CAUSE_OFS = 8'h08;
  localparam logic [7:0] PWR_STATUS_OFS = 8'h0C;
  localparam logic [7:0] PORTA_WAKE_OFS = 8'h10;

  // Reset values
  localparam logic [7:0] WDT_CTRL_RESET = 8'h53;
  localparam logic [7:0] SYS_CLK_CTRL_RESET = 8'h00;
  localparam logic [7:0] PORTA_WAKE_RESET = 8'h00;

  // Field positions
  localparam int KEY_MSB = 7;
  localparam int KEY_LSB = 3;
  localparam int PERIOD_MSB = 2;
  localparam int CLK_SRC_BIT = 4;
  localparam int FAST_KEEP_BIT = 1;
  localparam int SLOW_KEEP_BIT = 0;
  localparam logic [7:0] SYS_CLK_CTRL_MASK = 8'hF7;
  localparam int KEY_RESET_BIT = 0;
  localparam int LV_CTRL_RESET_BIT = 1;
  localparam int LV_RESET_BIT = 2;
  localparam int PDF_BIT = 0;
  localparam int EXPIRY_BIT = 1;
  localparam int MODE_LSB = 2;
  localparam int WDT_ON_BIT = 5;

  // Key codes
  localparam logic [4:0] KEY_ENABLE = 5'h0A;
  localparam logic [4:0] KEY_DISABLE = 5'h15;

  localparam int WDT_CNT_W = 19;

  typedef enum logic [2:0] {
    MODE_RUN = 3'h0,
    MODE_SLEEP = 3'h1,
    MODE_IDLE0 = 3'h2,
    MODE_IDLE_BOTH = 3'h3,
    MODE_IDLE_FAST = 3'h4
  } power_mode_t;

  typedef struct packed {
    logic halt;
    logic clr_wdt;
  } cpu_event_t;

  typedef struct packed {
    logic fast_clk_en;
    logic slow_clk_en;
    logic cpu_halted;
  } clk_gate_t;

  function automatic logic [WDT_CNT_W-1:0] wdt_period(input logic [2:0] sel);
    case (sel)
      3'h0: wdt_period = 19'h00100;
      3'h1: wdt_period = 19'h00400;
      3'h2: wdt_period = 19'h01000;
      3'h3: wdt_period = 19'h04000;
      3'h4: wdt_period = 19'h08000;
      3'h5: wdt_period = 19'h10000;
      3'h6: wdt_period = 19'h20000;
      default: wdt_period = 19'h40000;
    endcase
  endfunction

endpackage

// >>> logic/wdt_counter.sv
`timescale 1ns/1ps
module wdt_counter (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic clear_in,
  input wire logic enable_in,
  input wire logic [2:0] period_sel_in,
  output logic overflow_out,
  output logic [wdt_pkg::WDT_CNT_W-1:0] count_out
);
  import wdt_pkg::*;

  logic [WDT_CNT_W-1:0] count_q;
  logic [WDT_CNT_W-1:0] count_d;
  logic overflow_q;
  logic overflow_d;
  wire logic [WDT_CNT_W-1:0] last_count = wdt_period(period_sel_in) - 19'h00001;
  wire logic at_last = (count_q >= last_count);

  // Clear wins over counting; a tick at the last count wraps and flags overflow
  always_comb begin
    count_d = count_q;
    overflow_d = 1'b0;
    if (clear_in) begin
      count_d = '0;
    end else if (enable_in && tick_in) begin
      if (at_last) begin
        count_d = '0;
        overflow_d = 1'b1;
      end else begin
        count_d = count_q + 19'h00001;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      count_q <= '0;
      overflow_q <= 1'b0;
    end else begin
      count_q <= count_d;
      overflow_q <= overflow_d;
    end
  end

  assign overflow_out = overflow_q;
  assign count_out = count_q;

endmodule // wdt_counter

// >>> sim/wdt_power_ctrl_chk.sv
`timescale 1ns/1ps
module wdt_power_ctrl_chk #(
  parameter int PORTA_WIDTH = 8,
  parameter int IRQ_COUNT = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [wdt_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire wdt_pkg::cpu_event_t cpu_event_in,
  input wire logic [IRQ_COUNT-1:0] irq_req_in,
  input wire logic [IRQ_COUNT-1:0] irq_enable_in,
  input wire logic stack_full_in,
  input wire wdt_pkg::clk_gate_t clk_gate_out,
  input wire logic device_reset_out,
  input wire logic pc_sp_reset_out,
  input wire logic resume_out,
  input wire logic irq_service_out
);
  import wdt_pkg::*;
  logic [1:0] keep_q;
  logic [1:0] keep_d;
  wire apb_wr = psel_in && penable_in && pwrite_in;
  wire [4:0] wr_key = pwdata_in[KEY_MSB:KEY_LSB];
  wire key_bad = apb_wr && paddr_in == WDT_CTRL_OFS && wr_key != KEY_ENABLE
    && wr_key != KEY_DISABLE;
  wire [3:0] pulses = {device_reset_out, pc_sp_reset_out, resume_out, irq_service_out};
  wire running = !clk_gate_out.cpu_halted;
  // Shadow of the keep-on bits, so halt outcomes can be predicted
  assign keep_d = (apb_wr && paddr_in == SYS_CLK_CTRL_OFS) ? pwdata_in[1:0] : keep_q;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      keep_q <= 2'h0;
    end else begin
      keep_q <= keep_d;
    end
  end
  // Cycles since a bad key was written; the delayed reset is due at count 1002
  logic [10:0] key_wait_q;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      key_wait_q <= 11'h000;
    end else if (key_bad) begin
      key_wait_q <= 11'h001;
    end else if (key_wait_q == 11'h3EA) begin
      key_wait_q <= 11'h000;
    end else if (key_wait_q != 11'h000) begin
      key_wait_q <= key_wait_q + 11'h001;
    end
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_halt_taken;
    running && cpu_event_in.halt;
  endsequence
  sequence s_wake;
    pulses[2:0] != 3'h0;
  endsequence
  a_halt_enters: assert property (s_halt_taken |=> clk_gate_out.cpu_halted)
    else $error("halt did not stop the program");
  a_idle_both: assert property (keep_q == 2'h3 ##0 s_halt_taken |=> clk_gate_out == 3'h7)
    else $error("idle with both clocks not entered");
  a_idle_fast: assert property (keep_q == 2'h2 ##0 s_halt_taken |=> clk_gate_out == 3'h5)
    else $error("fast-only idle not entered");
  a_halted_hold: assert property (clk_gate_out.cpu_halted |=>
    $stable(clk_gate_out) || pulses[2:0] != 3'h0)
    else $error("power state changed without a wake");
  a_wake_from_halt: assert property (s_wake |-> running && $past(clk_gate_out.cpu_halted))
    else $error("wake pulse outside power-down");
  a_pulse_single: assert property ($onehot0(pulses))
    else $error("several wake or reset pulses at once");
  a_irq_svc_cause: assert property (irq_service_out |->
    $past(!stack_full_in && (irq_req_in & irq_enable_in) != '0))
    else $error("interrupt response without enabled request and free stack");
  a_key_delay: assert property (key_wait_q != 11'h000 |->
    device_reset_out == (key_wait_q == 11'h3EA))
    else $error("bad key did not reset after the fixed delay");
endmodule // wdt_power_ctrl_chk
bind wdt_power_ctrl wdt_power_ctrl_chk #(.PORTA_WIDTH(PORTA_WIDTH), .IRQ_COUNT(IRQ_COUNT)) i_chk (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .cpu_event_in(cpu_event_in), .irq_req_in(irq_req_in), .irq_enable_in(irq_enable_in),
  .stack_full_in(stack_full_in), .clk_gate_out(clk_gate_out),
  .device_reset_out(device_reset_out), .pc_sp_reset_out(pc_sp_reset_out),
  .resume_out(resume_out), .irq_service_out(irq_service_out));

// >>> sim/watchdog_and_power_down_wake_tb_top.sv
`timescale 1ns/1ps
module watchdog_and_power_down_wake_tb_top;
  import wdt_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  cpu_event_t cpu_event_in = '0;
  logic [7:0] porta_in = 8'hFF;
  logic ext_crystal_32k_in = 1'b0;
  logic [3:0] irq_req_in = 4'h0;
  logic [3:0] irq_enable_in = 4'h0;
  logic stack_full_in = 1'b0;
  logic low_voltage_reset_in = 1'b0;
  logic lv_control_reset_in = 1'b0;
  clk_gate_t clk_gate_out;
  logic device_reset_out, pc_sp_reset_out, resume_out, irq_service_out;
  logic [2:0] xdiv = 3'h0;
  logic [32:0] rd_q[$];
  logic [3:0] pl_q[$];
  logic [32:0] rd_exp;
  int bad_count = 0;
  int n_checks = 0;
  int seen = 0;
  int pin;
  int s;

  wdt_power_ctrl #(.PORTA_WIDTH(8), .IRQ_COUNT(4)) i_wdt_power_ctrl (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .cpu_event_in(cpu_event_in), .porta_in(porta_in),
    .ext_crystal_32k_in(ext_crystal_32k_in), .irq_req_in(irq_req_in),
    .irq_enable_in(irq_enable_in), .stack_full_in(stack_full_in),
    .low_voltage_reset_in(low_voltage_reset_in), .lv_control_reset_in(lv_control_reset_in),
    .clk_gate_out(clk_gate_out), .device_reset_out(device_reset_out),
    .pc_sp_reset_out(pc_sp_reset_out), .resume_out(resume_out),
    .irq_service_out(irq_service_out));

  always #50 sys_clk_in = ~sys_clk_in;

  // Crystal stand-in: one rising edge every 8 system clocks
  always @(posedge sys_clk_in) begin
    xdiv <= xdiv + 3'h1;
    ext_crystal_32k_in <= xdiv[2];
  end

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic give_up(input string what);
    bad_count++;
    $display("unexpected timeout in %s", what);
    tally_and_finish();
  endtask

  // Watcher: each completed read or output pulse consumes the oldest note
  always @(posedge sys_clk_in) begin
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in) begin
      rd_exp = rd_q.pop_front();
      check("read data", prdata_out, rd_exp[31:0]);
      check("slave error", 32'(pslverr_out), 32'(rd_exp[32]));
    end
    if ({device_reset_out, pc_sp_reset_out, resume_out, irq_service_out} !== 4'h0) begin
      seen++;
      check("pulse set", 32'({device_reset_out, pc_sp_reset_out, resume_out,
        irq_service_out}), 32'(pl_q.pop_front()));
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'($urandom()), d};
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 50);
    if (k >= 50) begin
      give_up("bus access");
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic e = 1'b0);
    rd_q.push_back({e, 24'h0, d});
    apb(1'b0, a, 8'h00);
  endtask

  task automatic expect_pulse(input logic [3:0] p, input int lim);
    int s0;
    int k;
    pl_q.push_back(p);
    s0 = seen;
    for (k = 0; k < lim && seen == s0; k++) begin
      @(negedge sys_clk_in);
    end
    if (seen == s0) begin
      give_up("pulse wait");
    end
    @(posedge sys_clk_in);
  endtask

  task automatic cpu(input logic h, input logic c);
    @(posedge sys_clk_in);
    cpu_event_in <= '{halt: h, clr_wdt: c};
    @(posedge sys_clk_in);
    cpu_event_in <= '0;
  endtask

  task automatic gate(input logic [2:0] g);
    @(negedge sys_clk_in);
    check("clock gates", 32'(clk_gate_out), 32'(g));
  endtask

  task automatic porta_wake();
    porta_in[pin] <= 1'b0;
    expect_pulse(4'h2, 20);
    porta_in[pin] <= 1'b1;
  endtask

  initial begin
    void'($urandom(41));
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd(WDT_CTRL_OFS, 8'h53);
    rd(SYS_CLK_CTRL_OFS, 8'h00);
    rd(RESET_CAUSE_OFS, 8'h00);
    rd(PWR_STATUS_OFS, 8'h20);
    rd(8'h14, 8'h00, 1'b1);
    wr(PWR_STATUS_OFS, 8'hFF);
    wr(WDT_CTRL_OFS, 8'hAB);
    rd(PWR_STATUS_OFS, 8'h00);
    wr(WDT_CTRL_OFS, 8'h53);
    wr(SYS_CLK_CTRL_OFS, 8'h03);
    cpu(1'b1, 1'b0);
    gate(3'h7);
    rd(PWR_STATUS_OFS, 8'h2D);
    rd(SYS_CLK_CTRL_OFS, 8'h03);
    pin = $urandom % 8;
    wr(PORTA_WAKE_OFS, 8'h01 << pin);
    porta_wake();
    cpu(1'b0, 1'b1);
    rd(PWR_STATUS_OFS, 8'h20);
    wr(SYS_CLK_CTRL_OFS, 8'h02);
    cpu(1'b1, 1'b0);
    gate(3'h5);
    rd(PWR_STATUS_OFS, 8'h31);
    irq_enable_in <= 4'h1;
    irq_req_in <= 4'h1;
    expect_pulse(4'h1, 10);
    irq_req_in <= 4'h0;
    cpu(1'b1, 1'b0);
    stack_full_in <= 1'b1;
    irq_req_in <= 4'h1;
    expect_pulse(4'h2, 10);
    stack_full_in <= 1'b0;
    // Request already pending at halt must not wake
    cpu(1'b1, 1'b0);
    repeat (20) @(posedge sys_clk_in);
    gate(3'h5);
    porta_wake();
    irq_req_in <= 4'h0;
    wr(SYS_CLK_CTRL_OFS, 8'h10);
    wr(WDT_CTRL_OFS, 8'h50);
    cpu(1'b1, 1'b0);
    gate(3'h1);
    expect_pulse(4'h4, 3000);
    rd(PWR_STATUS_OFS, 8'h23);
    expect_pulse(4'h8, 3000);
    rd(PWR_STATUS_OFS, 8'h23);
    wr(WDT_CTRL_OFS, 8'hA8);
    cpu(1'b1, 1'b0);
    s = seen;
    repeat (2500) @(posedge sys_clk_in);
    check("pulses while stopped", 32'(seen), 32'(s));
    porta_wake();
    cpu(1'b0, 1'b1);
    wr(WDT_CTRL_OFS, 8'hF8);
    expect_pulse(4'h8, 1100);
    rd(WDT_CTRL_OFS, 8'h53);
    rd(RESET_CAUSE_OFS, 8'h01);
    wr(RESET_CAUSE_OFS, 8'h01);
    rd(RESET_CAUSE_OFS, 8'h01);
    low_voltage_reset_in <= 1'b1;
    lv_control_reset_in <= 1'b1;
    @(posedge sys_clk_in);
    low_voltage_reset_in <= 1'b0;
    lv_control_reset_in <= 1'b0;
    rd(RESET_CAUSE_OFS, 8'h07);
    wr(RESET_CAUSE_OFS, 8'h00);
    rd(RESET_CAUSE_OFS, 8'h00);
    tally_and_finish();
  end
endmodule // watchdog_and_power_down_wake_tb_top
